/* File: pc_decode_pkg.sv */
// constants and types for the halfword instruction decode and program counter unit
// assumes an apb master on pclk; no other package is needed
package pc_decode_pkg;

    // ==========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFF_CTRL    = 8'h00; // write bit 0: decode one instruction
    localparam logic [7:0] OFF_INSTR   = 8'h04; // first halfword low, second high
    localparam logic [7:0] OFF_PC      = 8'h08; // program counter
    localparam logic [7:0] OFF_FLAGS   = 8'h0c; // n z c v in bits 3..0
    localparam logic [7:0] OFF_OPERAND = 8'h10; // source register or popped value
    localparam logic [7:0] OFF_STATUS  = 8'h14; // decode outcome
    localparam logic [7:0] OFF_LINK    = 8'h18; // return address of a call
    localparam logic [7:0] OFF_DECODE  = 8'h1c; // register indices and length
    localparam logic [7:0] OFF_ALIGNPC = 8'h20; // pc value seen, word aligned
    localparam logic [7:0] OFF_ATTR    = 8'h24; // exported memory attributes

    // ==========================================================
    // field positions and reset values
    localparam int          CTRL_STEP_BIT = 0;
    localparam int          ATTR_W        = 4;
    localparam logic [31:0] PC_RST        = 32'h0000_0000;
    localparam logic [3:0]  FLAGS_RST     = 4'h0;
    localparam logic [3:0]  ATTR_RST      = 4'h0;
    localparam logic [31:0] PC_AHEAD      = 32'h0000_0004; // pc seen by an instruction
    localparam logic [31:0] HALF_STEP     = 32'h0000_0002;
    localparam logic [31:0] WORD_ALIGN    = 32'hffff_fffc;

    // ==========================================================
    // what one decode did
    typedef enum logic [3:0] {
        K_NONE, K_SEQ, K_BRANCH_IMM, K_BRANCH_COND, K_LONG_CALL, K_BRANCH_EXCH,
        K_CALL_EXCH, K_POP_PC, K_ADD_PC, K_MOV_PC, K_BREAKPOINT, K_SUPERVISOR,
        K_UNDEF, K_UNSUPPORTED
    } kind_t;

    // status word as read by software
    typedef struct packed {
        logic        is_32;      // instruction was 32 bits long
        logic        cond_fail;  // condition test failed, acted as no-op
        logic        exception;  // breakpoint or supervisor call
        logic        fault;      // illegal state, undefined or unsupported
        logic        state_bad;  // interworking target had bit 0 clear
        kind_t       kind;       // decoded class
    } status_t;

endpackage : pc_decode_pkg

/* File: cond_test.sv */
// condition test of the flag nibble against a four-bit condition field
// assumes flags arrive as {n, z, c, v}; purely combinational
`timescale 1ns/100ps
module cond_test
    import pc_decode_pkg::*;
(
    // inputs
    input  wire logic [3:0] cond,
    input  wire logic [3:0] flags,
    // result
    output logic            pass
);
    logic n, z, c, v; // unpacked flags
    logic base;       // result before inversion

    // ==========================================================
    // flag test
    always_comb begin
        {n, z, c, v} = flags;
        unique case (cond[3:1])
            3'h0: base = z;
            3'h1: base = c;
            3'h2: base = n;
            3'h3: base = v;
            3'h4: base = c & ~z;
            3'h5: base = (n == v);
            3'h6: base = (n == v) & ~z;
            3'h7: base = 1'b1;
        endcase
        // odd codes invert, except the always code
        pass = (cond[0] && cond != 4'hf) ? ~base : base;
    end
endmodule : cond_test

/* File: compact_isa_pc_update_decode.sv */
// decode and program counter update unit, programmed over apb
// assumes software loads instr, pc, flags and operand, then writes ctrl bit 0
// Summary of operation
// - mixed 16/32-bit, halfword aligned instructions
// - most short forms reach registers 0-7
// - few short forms reach registers 8-15
// - interworking target bit 0 clear faults
// - pc writes drop bit 0
// - reg branch, reg call, pop interwork
// - add/mov to pc skip state check
// - immediate branches skip state check
// - breakpoint, supervisor call raise exception
// - long call only 32-bit pc writer
// - failed condition acts as no-op
// - only short conditional branch, -256..+254
// - no wide conditional, compare-branch, predication
// - permanently undefined encodings recognised
// - each operation has one width only
// - no cache control, attributes exported
// - pc seen is address plus 4
`timescale 1ns/100ps
module compact_isa_pc_update_decode
    import pc_decode_pkg::*;
(
    // apb clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb request
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    // apb answer
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // system bus view
    output logic [31:0]            fetch_addr,
    output logic [ATTR_W-1:0]      mem_attr,
    output logic                   decode_fault
);
    // ==========================================================
    // state
    logic [31:0]       instr_r, instr_nxt;     // instruction halfwords
    logic [31:0]       pc_r, pc_nxt;           // program counter
    logic [3:0]        flags_r, flags_nxt;     // n z c v
    logic [31:0]       oper_r, oper_nxt;       // target operand
    logic [31:0]       link_r, link_nxt;       // call return address
    logic [ATTR_W-1:0] attr_r, attr_nxt;       // exported attributes
    status_t           stat_r, stat_nxt;       // last decode outcome
    logic [8:0]        dec_r, dec_nxt;         // {is_32, src idx, dst idx}
    logic              step_r, step_nxt;       // decode pulse
    logic [31:0]       prdata_r, prdata_nxt;   // read data
    logic              pready_r, pready_nxt;   // access done
    logic              pslverr_r, pslverr_nxt; // unmapped access
    logic              fault_r, fault_nxt;     // fault pin

    // ==========================================================
    // decode combinational signals
    logic [15:0] hw0, hw1;        // first and second halfword
    logic        wide;            // 32-bit encoding
    logic        cpass;           // condition held
    logic [31:0] pc_seen;         // pc as an instruction reads it
    logic [31:0] seq_pc;          // next sequential address
    logic [31:0] br_off;          // branch offset
    logic [31:0] target;          // new pc before bit 0 drop
    logic        do_branch;       // pc changes
    logic        check_state;     // interworking check applies
    kind_t       kind;            // class of instruction
    logic [3:0]  src_idx, dst_idx;// register indices
    logic        s_b, i1_b, i2_b; // long call sign and bits
    logic        access;          // apb access phase

    // access qualifies only the first access-phase cycle; the raised
    // ready then masks it so one transfer never acts twice
    assign hw0     = instr_r[15:0];
    assign hw1     = instr_r[31:16];
    assign pc_seen = pc_r + PC_AHEAD;
    assign access  = psel & penable & ~pready_r;

    // flag test for the conditional branch
    cond_test u_cond (
        .cond  (hw0[11:8]),
        .flags (flags_r),
        .pass  (cpass)
    );

    // ==========================================================
    // instruction classifier
    always_comb begin
        // three top patterns start a 32-bit encoding
        wide        = (hw0[15:11] == 5'h1d) || (hw0[15:11] == 5'h1e) ||
                      (hw0[15:11] == 5'h1f);
        kind        = K_SEQ;
        br_off      = 32'h0;
        check_state = 1'b0;
        src_idx     = {1'b0, hw0[5:3]};      // low registers only
        dst_idx     = {1'b0, hw0[2:0]};
        s_b         = hw0[10];
        i1_b        = ~(hw1[13] ^ s_b);
        i2_b        = ~(hw1[11] ^ s_b);
        if (wide) begin
            // one operation, one width; nothing else here writes pc
            if (hw0[15:11] == 5'h1e && hw1[15:14] == 2'h3 && hw1[12]) begin
                kind   = K_LONG_CALL;
                // 25-bit signed offset: eight sign copies fill the word
                br_off = {{8{s_b}}, i1_b, i2_b, hw0[9:0], hw1[10:0], 1'b0};
            end else if (hw0[15:4] == 12'hf7f && hw1[15:12] == 4'ha) begin
                kind = K_UNDEF;
            end else if (hw0[15:11] == 5'h1e && hw1[15:14] == 2'h2 && !hw1[12]
                         && hw0[9:7] != 3'h7) begin
                kind = K_UNSUPPORTED;   // wide conditional branch
            end
        end else if (hw0[15:7] == 9'h08e) begin
            kind        = K_BRANCH_EXCH;
            check_state = 1'b1;
            src_idx     = hw0[6:3];
        end else if (hw0[15:7] == 9'h08f) begin
            kind        = K_CALL_EXCH;
            check_state = 1'b1;
            src_idx     = hw0[6:3];
        end else if (hw0[15:8] == 8'hbd) begin
            kind        = K_POP_PC;
            check_state = 1'b1;
        end else if (hw0[15:8] == 8'h44 || hw0[15:8] == 8'h46) begin
            // high register add and move
            src_idx = hw0[6:3];
            dst_idx = {hw0[7], hw0[2:0]};
            if (dst_idx == 4'hf)
                kind = (hw0[9]) ? K_MOV_PC : K_ADD_PC;
        end else if (hw0[15:8] == 8'hbe) begin
            kind = K_BREAKPOINT;
        end else if (hw0[15:8] == 8'hde) begin
            kind = K_UNDEF;
        end else if (hw0[15:8] == 8'hdf) begin
            kind = K_SUPERVISOR;
        end else if (hw0[15:12] == 4'hd) begin
            kind   = K_BRANCH_COND;
            br_off = {{23{hw0[7]}}, hw0[7:0], 1'b0};            // -256..+254
        end else if (hw0[15:11] == 5'h1c) begin
            kind   = K_BRANCH_IMM;
            br_off = {{20{hw0[10]}}, hw0[10:0], 1'b0};
        end else if ((hw0[15:12] == 4'hb && hw0[10] == 1'b0 && hw0[8]) ||
                     (hw0[15:8] == 8'hbf && hw0[3:0] != 4'h0)) begin
            kind = K_UNSUPPORTED;  // compare-branch, if_then_block
        end
    end

    // ==========================================================
    // pc update selection
    always_comb begin
        seq_pc    = wide ? pc_seen : pc_r + HALF_STEP;
        target    = seq_pc;
        do_branch = 1'b0;
        // register targets keep bit 0 here; it is dropped at the load
        unique case (kind)
            K_BRANCH_IMM, K_LONG_CALL: begin
                target    = pc_seen + br_off;
                do_branch = 1'b1;
            end
            K_BRANCH_COND: begin
                // failed test falls through as a no-op
                target    = cpass ? pc_seen + br_off : seq_pc;
                do_branch = cpass;
            end
            K_BRANCH_EXCH, K_CALL_EXCH, K_POP_PC, K_MOV_PC: begin
                target    = oper_r;
                do_branch = 1'b1;
            end
            K_ADD_PC: begin
                target    = pc_seen + oper_r;
                do_branch = 1'b1;
            end
            default: begin
                target    = seq_pc;
                do_branch = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // decode state next values
    always_comb begin
        pc_nxt    = pc_r;
        link_nxt  = link_r;
        stat_nxt  = stat_r;
        dec_nxt   = dec_r;
        fault_nxt = fault_r;
        if (step_r) begin
            stat_nxt.is_32     = wide;
            stat_nxt.kind      = kind;
            stat_nxt.cond_fail = (kind == K_BRANCH_COND) && !cpass;
            stat_nxt.state_bad = check_state && !oper_r[0];
            stat_nxt.exception = (kind == K_BREAKPOINT) ||
                                 (kind == K_SUPERVISOR);
            stat_nxt.fault     = (check_state && !oper_r[0]) ||
                                 (kind == K_UNDEF) ||
                                 (kind == K_UNSUPPORTED);
            dec_nxt            = {wide, src_idx, dst_idx};
            fault_nxt          = stat_nxt.fault;
            // fault or exception leaves pc and link untouched
            if (!stat_nxt.fault && !stat_nxt.exception) begin
                pc_nxt = {target[31:1], 1'b0};
                if (kind == K_LONG_CALL)
                    link_nxt = {pc_seen[31:1], 1'b1};
                else if (kind == K_CALL_EXCH)
                    link_nxt = {seq_pc[31:1], 1'b1};
            end
        end
        // a software counter write lands after the step and so wins
        if (access && pwrite && paddr == OFF_PC)
            pc_nxt = {pwdata[31:1], 1'b0};
    end

    // ==========================================================
    // apb slave next values
    always_comb begin
        instr_nxt   = instr_r;
        flags_nxt   = flags_r;
        oper_nxt    = oper_r;
        attr_nxt    = attr_r;
        step_nxt    = 1'b0;
        prdata_nxt  = prdata_r;
        pready_nxt  = access;   // one wait state, then done
        pslverr_nxt = 1'b0;
        if (access) begin
            prdata_nxt = 32'h0;
            unique case (paddr)
                OFF_CTRL:    step_nxt = pwrite & pwdata[CTRL_STEP_BIT];
                OFF_INSTR:   if (pwrite) instr_nxt = pwdata;
                OFF_PC:      ;
                OFF_FLAGS:   if (pwrite) flags_nxt = pwdata[3:0];
                OFF_OPERAND: if (pwrite) oper_nxt = pwdata;
                OFF_STATUS, OFF_LINK, OFF_DECODE, OFF_ALIGNPC: ;
                OFF_ATTR:    if (pwrite) attr_nxt = pwdata[ATTR_W-1:0];
                default:     pslverr_nxt = 1'b1;
            endcase
            if (!pwrite) begin
                unique case (paddr)
                    OFF_INSTR:   prdata_nxt = instr_r;
                    OFF_PC:      prdata_nxt = pc_r;
                    OFF_FLAGS:   prdata_nxt = {28'h0, flags_r};
                    OFF_OPERAND: prdata_nxt = oper_r;
                    OFF_STATUS:  prdata_nxt = {23'h0, stat_r};
                    OFF_LINK:    prdata_nxt = link_r;
                    OFF_DECODE:  prdata_nxt = {23'h0, dec_r};
                    OFF_ALIGNPC: prdata_nxt = pc_seen & WORD_ALIGN;
                    OFF_ATTR:    prdata_nxt = {{(32-ATTR_W){1'b0}}, attr_r};
                    default:     prdata_nxt = 32'h0;
                endcase
            end
        end
    end

    // ==========================================================
    // registers
    // every state flop clears together; no reset value depends on inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_r   <= 32'h0;
            pc_r      <= PC_RST;
            flags_r   <= FLAGS_RST;
            oper_r    <= 32'h0;
            link_r    <= 32'h0;
            attr_r    <= ATTR_RST;
            stat_r    <= '0;
            dec_r     <= 9'h0;
            step_r    <= 1'b0;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            fault_r   <= 1'b0;
        end else begin
            instr_r   <= instr_nxt;
            pc_r      <= pc_nxt;
            flags_r   <= flags_nxt;
            oper_r    <= oper_nxt;
            link_r    <= link_nxt;
            attr_r    <= attr_nxt;
            stat_r    <= stat_nxt;
            dec_r     <= dec_nxt;
            step_r    <= step_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            fault_r   <= fault_nxt;
        end
    end

    // outputs straight from flops
    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign fetch_addr   = pc_r;
    assign mem_attr     = attr_r;
    assign decode_fault = fault_r;
endmodule : compact_isa_pc_update_decode

/* File: decode_checker_properties.sv */
// assertion checker for the decode unit, watching only its top-level ports
// assumes one pclk domain and the bind at the foot of this file
`timescale 1ns/100ps
module decode_checker
    import pc_decode_pkg::*;
(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb request
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    // apb answer
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // system bus view
    input wire logic [31:0]       fetch_addr,
    input wire logic [ATTR_W-1:0] mem_attr,
    input wire logic              decode_fault
);
    // ==========================================================
    // helper strobes
    logic step_req; // completed write that starts a decode
    logic pc_wr;    // completed write to the counter
    assign step_req = pready && pwrite && paddr == OFF_CTRL && pwdata[CTRL_STEP_BIT];
    assign pc_wr    = pready && pwrite && paddr == OFF_PC;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // properties
    chk_pc_even: assert property (fetch_addr[0] == 1'b0)
        else $error("counter bit 0 set");
    chk_pc_write: assert property (pc_wr |-> fetch_addr == {pwdata[31:1], 1'b0})
        else $error("counter write not taken as bits 31 to 1");
    chk_pc_cause: assert property ($changed(fetch_addr) |->
        pc_wr || $past(step_req) || $past(step_req, 2) || $past(step_req, 3))
        else $error("counter moved without a write or a step");
    chk_fault_cause: assert property ($changed(decode_fault) |->
        $past(step_req) || $past(step_req, 2) || $past(step_req, 3))
        else $error("fault flag moved without a step");
    chk_attr_write: assert property (pready && pwrite && paddr == OFF_ATTR
        |-> mem_attr == pwdata[ATTR_W-1:0])
        else $error("attributes not exported as written");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_time: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    chk_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : decode_checker

bind compact_isa_pc_update_decode decode_checker i_decode_checker (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .mem_attr(mem_attr), .decode_fault(decode_fault));

/* File: sys_mem_model.sv */
// system bus side model: samples the fetch address and exported attributes
// assumes one pclk domain; holds no cache and issues no maintenance
`timescale 1ns/100ps
module sys_mem_model
    import pc_decode_pkg::*;
(
    // bus side
    input  wire logic              pclk,
    input  wire logic [31:0]       fetch_addr,
    input  wire logic [ATTR_W-1:0] mem_attr,
    // what the system saw
    output logic [31:0]            fetch_seen,
    output logic [ATTR_W-1:0]      attr_seen
);
    // ==========================================================
    // system caches only read the attributes
    // test code never puts pc as sp-add destination
    always_ff @(posedge pclk) begin
        fetch_seen <= fetch_addr;
        attr_seen  <= mem_attr;
    end
endmodule : sys_mem_model

/* File: tb_top.sv */
// testbench for the decode unit: apb tasks and table of decode cases
// assumes pc_decode_pkg, the checker bind and the system bus model
`timescale 1ns/100ps
module tb_top
    import pc_decode_pkg::*;
;
    // ==========================================================
    // signals
    logic              pclk, presetn, psel, penable, pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, fetch_addr, fetch_seen, r;
    logic              pready, pslverr, decode_fault, e;
    logic [ATTR_W-1:0] mem_attr, attr_seen;
    int                num_errors, num_checks;

    compact_isa_pc_update_decode i_compact_isa_pc_update_decode (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fetch_addr(fetch_addr), .mem_attr(mem_attr),
        .decode_fault(decode_fault));
    sys_mem_model i_sys_mem_model (.pclk(pclk), .fetch_addr(fetch_addr),
        .mem_attr(mem_attr), .fetch_seen(fetch_seen), .attr_seen(attr_seen));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // closing and comparing
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp_word

    // one apb transfer, then one idle edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) cmp_word(32'h0, 32'h1, "ready timeout");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // load one instruction, step, check counter and status
    task run_case(input logic [31:0] ins, input logic [3:0] fl, input logic [31:0] op,
                  input logic [31:0] pc_e, input logic [31:0] st_e);
        apb(1'b1, OFF_INSTR, ins);
        apb(1'b1, OFF_PC, 32'h101);
        apb(1'b1, OFF_FLAGS, {28'h0, fl});
        apb(1'b1, OFF_OPERAND, op);
        apb(1'b1, OFF_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        apb(1'b0, OFF_PC, 32'h0);
        cmp_word(r, pc_e, "pc");
        cmp_word(fetch_addr, pc_e, "fetch");
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp_word(r, st_e, "status");
        cmp_word({31'h0, decode_fault}, {31'h0, st_e[5]}, "fault pin");
        $display("case %h done", ins);
    endtask : run_case

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_PC, 32'h0);
        cmp_word(r, PC_RST, "pc reset");
        apb(1'b1, OFF_ATTR, 32'ha);
        apb(1'b0, OFF_ATTR, 32'h0);
        cmp_word(r, 32'ha, "attr");
        cmp_word({28'h0, attr_seen}, 32'ha, "attr seen");
        apb(1'b1, 8'h40, 32'h5);
        cmp_word({31'h0, e}, 32'h1, "write error");
        apb(1'b0, 8'h40, 32'h0);
        cmp_word({31'h0, e}, 32'h1, "read error");
        apb(1'b1, OFF_PC, 32'h102);
        apb(1'b0, OFF_ALIGNPC, 32'h0);
        cmp_word(r, 32'h104, "aligned pc");
        cmp_word(fetch_seen, 32'h102, "fetch seen");
        $display("register test done");
        run_case(32'h1888, 4'h0, 32'h0, 32'h102, 32'h01);
        apb(1'b0, OFF_DECODE, 32'h0);
        cmp_word(r, 32'h010, "low register fields");
        run_case(32'h8f5f_f3bf, 4'h0, 32'h0, 32'h104, 32'h101);
        run_case(32'he002, 4'h0, 32'h1, 32'h108, 32'h02);
        run_case(32'hd07f, 4'h4, 32'h0, 32'h202, 32'h03);
        run_case(32'hd080, 4'h4, 32'h0, 32'h004, 32'h03);
        run_case(32'hd17f, 4'h4, 32'h0, 32'h102, 32'h83);
        run_case(32'hda01, 4'h8, 32'h0, 32'h102, 32'h83);
        run_case(32'hd201, 4'h2, 32'h0, 32'h106, 32'h03);
        run_case(32'h4740, 4'h0, 32'h2001, 32'h2000, 32'h05);
        apb(1'b0, OFF_DECODE, 32'h0);
        cmp_word(r, 32'h080, "high register field");
        run_case(32'h4740, 4'h0, 32'h2000, 32'h100, 32'h35);
        run_case(32'h4788, 4'h0, 32'h3001, 32'h3000, 32'h06);
        apb(1'b0, OFF_LINK, 32'h0);
        cmp_word(r, 32'h103, "call link");
        run_case(32'hbd00, 4'h0, 32'h4000, 32'h100, 32'h37);
        run_case(32'h4487, 4'h0, 32'h10, 32'h114, 32'h08);
        run_case(32'h4687, 4'h0, 32'h500, 32'h500, 32'h09);
        run_case(32'hbe00, 4'h0, 32'h0, 32'h100, 32'h4a);
        run_case(32'hdf00, 4'h0, 32'h0, 32'h100, 32'h4b);
        run_case(32'hf800_f000, 4'h0, 32'h0, 32'h104, 32'h104);
        apb(1'b0, OFF_LINK, 32'h0);
        cmp_word(r, 32'h105, "long link");
        run_case(32'hfffc_f7ff, 4'h0, 32'h0, 32'h0fc, 32'h104);
        run_case(32'hde00, 4'h0, 32'h0, 32'h100, 32'h2c);
        run_case(32'ha000_f7f0, 4'h0, 32'h0, 32'h100, 32'h12c);
        run_case(32'hbf08, 4'h0, 32'h0, 32'h100, 32'h2d);
        run_case(32'hb100, 4'h0, 32'h0, 32'h100, 32'h2d);
        run_case(32'h8000_f000, 4'h0, 32'h0, 32'h100, 32'h12d);
        wrap_up;
    end

    // cut a hang short
    initial begin
        #100000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up;
    end
endmodule : tb_top
